// >>> eeprom_pkg.sv
// Constants, types and decode helpers shared by the serial EEPROM slave
package eeprom_pkg;

	localparam int WORD_W      = 16;
	localparam int ADDR_W      = 8;
	localparam int INDEX_W     = 7;
	localparam int DEPTH_WORDS = 128;
	localparam int FIFO_DEPTH  = 4;

	// Timing
	localparam int SYS_CLK_PERIOD_NS = 4;
	localparam int CS_LOW_MIN_US     = 1;
	localparam int CS_LOW_MIN_CYCLES = (CS_LOW_MIN_US * 1000 + SYS_CLK_PERIOD_NS - 1)
		/ SYS_CLK_PERIOD_NS;
	localparam int PROG_TIME_MS      = 15;
	localparam int PROG_CYCLES       = PROG_TIME_MS * 1000000 / SYS_CLK_PERIOD_NS;
	localparam int PROG_CNT_W        = 22;

	// Opcodes and the extended selector in the top two address bits
	localparam logic [1:0] OP_EXT              = 2'h0;
	localparam logic [1:0] OP_WRITE            = 2'h1;
	localparam logic [1:0] OP_READ             = 2'h2;
	localparam logic [1:0] OP_ERASE            = 2'h3;
	localparam logic [1:0] PROGRAM_DISABLE_CMD = 2'h0;
	localparam logic [1:0] FILL_ARRAY_CMD      = 2'h1;
	localparam logic [1:0] CLEAR_ARRAY_CMD     = 2'h2;
	localparam logic [1:0] PROGRAM_ENABLE_CMD  = 2'h3;
	localparam int         EXT_SEL_HI          = 7;
	localparam int         EXT_SEL_LO          = 6;

	localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;

	// Last bit index of each serial field
	localparam logic [4:0] OPC_LAST = 5'h01;
	localparam logic [4:0] ADR_LAST = 5'h07;
	localparam logic [4:0] DAT_LAST = 5'h0F;

	typedef logic [PROG_CNT_W-1:0] prog_cnt_type;

	typedef enum logic [2:0] {
		LNK_IDLE   = 3'h0,
		LNK_OPCODE = 3'h1,
		LNK_ADDR   = 3'h3,
		LNK_DATA   = 3'h2,
		LNK_DONE   = 3'h6,
		LNK_READ   = 3'h7
	} link_state_type;

	typedef enum logic {
		EXE_IDLE = 1'b0,
		EXE_PROG = 1'b1
	} exe_state_type;

	typedef struct packed {
		logic [1:0]        op;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
	} cmd_type;

	typedef struct packed {
		link_state_type    state;
		logic [4:0]        cnt;
		cmd_type           cmd;
		logic [WORD_W:0]   out_sr;
		logic              reading;
	} link_type;

	typedef struct packed {
		logic    valid;
		cmd_type cmd;
	} hold_type;

	typedef struct packed {
		logic cs;
		logic cmd_valid;
		logic reading;
		logic out_bit;
	} link_status_type;

	typedef struct packed {
		logic          cs_d;
		logic          valid_d;
		logic          armed;
		exe_state_type exe;
		logic          enable;
		prog_cnt_type  timer;
		cmd_type       prog;
		logic          so;
		logic          so_oe;
	} sys_type;

	function automatic logic [1:0] ext_sel(input cmd_type c);
		return c.addr[EXT_SEL_HI:EXT_SEL_LO];
	endfunction : ext_sel

	function automatic logic takes_data(input cmd_type c);
		return (c.op == OP_WRITE) || (c.op == OP_EXT && ext_sel(c) == FILL_ARRAY_CMD);
	endfunction : takes_data

	function automatic logic whole_array(input cmd_type c);
		return c.op == OP_EXT
			&& (ext_sel(c) == FILL_ARRAY_CMD || ext_sel(c) == CLEAR_ARRAY_CMD);
	endfunction : whole_array

	function automatic logic is_program(input cmd_type c);
		return (c.op == OP_WRITE) || (c.op == OP_ERASE) || whole_array(c);
	endfunction : is_program

endpackage : eeprom_pkg

// >>> bit_sync.sv
// Two-flop level synchroniser, one flop pair per bit
module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_type;

	sync_state_type s_r;
	sync_state_type s_nxt;

	always_comb begin
		s_nxt.meta   = async_in;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sync_out = s_r.stable;

endmodule : bit_sync

// >>> word_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int PTR_W = $clog2(DEPTH);

	typedef struct packed {
		logic [PTR_W:0] wr_ptr;
		logic [PTR_W:0] rd_ptr;
	} fifo_state_type;

	fifo_state_type   f_r;
	fifo_state_type   f_nxt;
	logic [WIDTH-1:0] store [DEPTH];
	logic             push;
	logic             pop;

	// Extra pointer bit tells full from empty
	assign out_valid = f_r.wr_ptr != f_r.rd_ptr;
	assign in_ready  = !((f_r.wr_ptr[PTR_W] != f_r.rd_ptr[PTR_W])
		&& (f_r.wr_ptr[PTR_W-1:0] == f_r.rd_ptr[PTR_W-1:0]));
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = store[f_r.rd_ptr[PTR_W-1:0]];

	always_comb begin
		f_nxt = f_r;
		if (push) begin
			f_nxt.wr_ptr = f_r.wr_ptr + 1'b1;
		end
		if (pop) begin
			f_nxt.rd_ptr = f_r.rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			f_r <= '0;
		end else begin
			f_r <= f_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			store[f_r.wr_ptr[PTR_W-1:0]] <= in_data;
		end
	end

endmodule : word_fifo

// >>> eeprom_serial_slave.sv
// Serial EEPROM slave: pin protocol, command queue and self-timed programming
//
// Summary of operation
// - Select is active high; only a high select allows serial traffic.
// - Rising select restarts the protocol machine; master must not hold select high.
// - Falling select after a complete write-type command starts programming.
// - With select low, clock, input and output activity is ignored.
// - Serial input is sampled on each rising shift clock edge.
// - Read data changes only after a rising shift clock edge; ready status can change without one.
// - Serial output is driven only while selected, otherwise released.
// - Shift clock and serial input are not gated; low select holds the protocol machine in reset.
// - A cycle begins on a 1 start bit; leading zeros are ignored.
// - 2-bit opcode, 8-bit address; low 7 bits index; opcode 00 uses top bits.
// - Read outputs a dummy zero, then 16 data bits MSB first.
// - While selected and programming, output shows 0; ready shows 1.
module eeprom_serial_slave
	import eeprom_pkg::*;
#(
	parameter int PROG_CYCLES_P = PROG_CYCLES
) (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic shift_clock,
	input  wire logic select,
	input  wire logic serial_in,
	output logic      serial_out,
	output logic      serial_out_oe
);

	// Link side state
	link_type                     lnk_r;
	link_type                     lnk_nxt;
	hold_type                     hold_r;
	hold_type                     hold_nxt;
	logic                         link_rst_b;
	logic [INDEX_W-1:0]           rd_index;

	// System side state
	sys_type                      st_r;
	sys_type                      st_nxt;
	link_status_type              stat_raw;
	link_status_type              stat_s;
	logic [$bits(link_status_type)-1:0] stat_vec;
	logic                         cs_fall;
	logic                         busy;

	// Array and its write port
	logic [WORD_W-1:0]            array_mem [DEPTH_WORDS];
	logic                         mem_we;
	logic                         mem_all;
	logic [INDEX_W-1:0]           mem_idx;
	logic [WORD_W-1:0]            mem_word;

	// Queue between capture and execution
	logic                         q_in_valid;
	logic                         q_in_ready;
	logic                         q_out_valid;
	logic                         q_out_ready;
	cmd_type                      q_out_data;

	// Low select holds the protocol machine in reset, so every frame
	// starts clean and clock edges while deselected do nothing
	assign link_rst_b = rst_b & select;

	// Index built from the current register and the incoming A0, so the
	// read port does not loop back through the next-state copy
	assign rd_index = {lnk_r.cmd.addr[INDEX_W-2:0], serial_in};

	always_comb begin
		lnk_nxt  = lnk_r;
		hold_nxt = hold_r;
		unique case (lnk_r.state)
			LNK_IDLE: begin
				if (serial_in) begin
					lnk_nxt.state = LNK_OPCODE;
					lnk_nxt.cnt   = '0;
				end
			end
			LNK_OPCODE: begin
				// Drop the previous frame's command once a new one is under way
				hold_nxt.valid = 1'b0;
				lnk_nxt.cmd.op = {lnk_r.cmd.op[0], serial_in};
				lnk_nxt.cnt    = lnk_r.cnt + 5'h01;
				if (lnk_r.cnt == OPC_LAST) begin
					lnk_nxt.state = LNK_ADDR;
					lnk_nxt.cnt   = '0;
				end
			end
			LNK_ADDR: begin
				lnk_nxt.cmd.addr = {lnk_r.cmd.addr[ADDR_W-2:0], serial_in};
				lnk_nxt.cnt      = lnk_r.cnt + 5'h01;
				if (lnk_r.cnt == ADR_LAST) begin
					lnk_nxt.cnt = '0;
					if (lnk_r.cmd.op == OP_READ) begin
						// Dummy zero leads, word follows MSB first
						lnk_nxt.state   = LNK_READ;
						lnk_nxt.reading = 1'b1;
						lnk_nxt.out_sr  = {1'b0, array_mem[rd_index]};
					end else if (takes_data(lnk_nxt.cmd)) begin
						lnk_nxt.state = LNK_DATA;
					end else begin
						lnk_nxt.state = LNK_DONE;
						hold_nxt      = '{valid: 1'b1, cmd: lnk_nxt.cmd};
					end
				end
			end
			LNK_DATA: begin
				lnk_nxt.cmd.data = {lnk_r.cmd.data[WORD_W-2:0], serial_in};
				lnk_nxt.cnt      = lnk_r.cnt + 5'h01;
				if (lnk_r.cnt == DAT_LAST) begin
					lnk_nxt.state = LNK_DONE;
					hold_nxt      = '{valid: 1'b1, cmd: lnk_nxt.cmd};
				end
			end
			LNK_DONE: begin
				// Surplus clocks after a complete command are ignored
				lnk_nxt = lnk_r;
			end
			LNK_READ: begin
				lnk_nxt.out_sr = {lnk_r.out_sr[WORD_W-1:0], 1'b0};
			end
			default: begin
				lnk_nxt.state = LNK_IDLE;
			end
		endcase
	end

	always_ff @(posedge shift_clock or negedge link_rst_b) begin
		if (!link_rst_b) begin
			lnk_r <= '{state: LNK_IDLE, default: '0};
		end else begin
			lnk_r <= lnk_nxt;
		end
	end

	// Outlives the frame: system side picks it up after select falls
	always_ff @(posedge shift_clock or negedge rst_b) begin
		if (!rst_b) begin
			hold_r <= '0;
		end else begin
			hold_r <= hold_nxt;
		end
	end

	assign stat_raw = '{
		cs:        select,
		cmd_valid: hold_r.valid,
		reading:   lnk_r.reading,
		out_bit:   lnk_r.out_sr[WORD_W]
	};

	bit_sync #(
		.WIDTH ($bits(link_status_type))
	) status_sync (
		.clk      (sys_clk),
		.rst_b    (rst_b),
		.async_in (stat_raw),
		.sync_out (stat_vec)
	);

	assign stat_s  = link_status_type'(stat_vec);
	assign cs_fall = st_r.cs_d & ~stat_s.cs;
	assign busy    = (st_r.exe == EXE_PROG) | q_out_valid;

	// Command word is static from valid until the next frame, which needs
	// a low select far longer than the synchroniser, so no word sync
	assign q_in_valid = cs_fall & st_r.armed & ~busy;

	word_fifo #(
		.WIDTH ($bits(cmd_type)),
		.DEPTH (FIFO_DEPTH)
	) cmd_queue (
		.clk       (sys_clk),
		.rst_b     (rst_b),
		.in_valid  (q_in_valid),
		.in_ready  (q_in_ready),
		.in_data   (hold_r.cmd),
		.out_valid (q_out_valid),
		.out_ready (q_out_ready),
		.out_data  (q_out_data)
	);

	always_comb begin
		st_nxt      = st_r;
		mem_we      = 1'b0;
		mem_all     = 1'b0;
		mem_idx     = st_r.prog.addr[INDEX_W-1:0];
		mem_word    = st_r.prog.data;
		q_out_ready = 1'b0;

		st_nxt.cs_d    = stat_s.cs;
		st_nxt.valid_d = stat_s.cmd_valid;
		// Only a command completed in this frame counts; a stale one never rises
		if (stat_s.cmd_valid && !st_r.valid_d && stat_s.cs) begin
			st_nxt.armed = 1'b1;
		end
		if (cs_fall && !(q_in_valid && !q_in_ready)) begin
			st_nxt.armed = 1'b0;
		end

		unique case (st_r.exe)
			EXE_IDLE: begin
				q_out_ready = 1'b1;
				if (q_out_valid) begin
					if (q_out_data.op == OP_EXT && ext_sel(q_out_data) == PROGRAM_ENABLE_CMD) begin
						st_nxt.enable = 1'b1;
					end else if (q_out_data.op == OP_EXT
						&& ext_sel(q_out_data) == PROGRAM_DISABLE_CMD) begin
						st_nxt.enable = 1'b0;
					end else if (st_r.enable && is_program(q_out_data)) begin
						st_nxt.exe   = EXE_PROG;
						st_nxt.timer = prog_cnt_type'(PROG_CYCLES_P - 1);
						st_nxt.prog  = q_out_data;
					end
				end
			end
			EXE_PROG: begin
				if (st_r.timer == '0) begin
					// Array changes only at the end of the self-timed window
					mem_we     = 1'b1;
					mem_all    = whole_array(st_r.prog);
					st_nxt.exe = EXE_IDLE;
				end else begin
					st_nxt.timer = st_r.timer - 1'b1;
				end
			end
		endcase

		if (st_r.prog.op == OP_ERASE || ext_sel(st_r.prog) == CLEAR_ARRAY_CMD) begin
			if (st_r.prog.op != OP_WRITE) begin
				mem_word = ERASED_WORD;
			end
		end

		// Busy overrides read data so a read started while busy shows 0 until busy ends
		st_nxt.so_oe = stat_s.cs;
		st_nxt.so    = (stat_s.reading && !busy) ? stat_s.out_bit : ~busy;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '{exe: EXE_IDLE, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Powers up erased; link reads it at any time, even while programming runs
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < DEPTH_WORDS; i++) begin
				array_mem[i] <= ERASED_WORD;
			end
		end else if (mem_we) begin
			for (int i = 0; i < DEPTH_WORDS; i++) begin
				if (mem_all || mem_idx == INDEX_W'(i)) begin
					array_mem[i] <= mem_word;
				end
			end
		end
	end

	assign serial_out    = st_r.so;
	assign serial_out_oe = st_r.so_oe;

endmodule : eeprom_serial_slave

// >>> eeprom_serial_slave_asserts.sv
// Port-level checks for the serial EEPROM slave
module eeprom_serial_slave_asserts
	import eeprom_pkg::*;
#(
	parameter int PROG_CYCLES_P = PROG_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic shift_clock,
	input wire logic select,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic [3:0]  idle_r;
	logic [31:0] busy_r;
	// Idle count saturates so a stopped clock never wraps it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			idle_r <= 4'h0;
			busy_r <= 32'h0;
		end else begin
			idle_r <= shift_clock ? 4'h0 : (idle_r == 4'hF ? idle_r : idle_r + 4'h1);
			busy_r <= (serial_out_oe && !serial_out && idle_r >= 4'h8) ? busy_r + 32'h1 : 32'h0;
		end
	end
	a_oe_after_select: assert property ($rose(select) |-> ##[1:5] serial_out_oe)
		else $error("output not driven after select");
	a_oe_release: assert property ($fell(select) |-> ##[1:5] !serial_out_oe)
		else $error("output not released after deselect");
	a_oe_held_off: assert property (!select [*6] |-> !serial_out_oe)
		else $error("output driven while deselected");
	a_oe_held_on: assert property (select [*6] |-> serial_out_oe)
		else $error("output idle while selected");
	a_oe_rise_cause: assert property ($rose(serial_out_oe) |-> $past(select, 2))
		else $error("output enable rose without select");
	a_oe_fall_cause: assert property ($fell(serial_out_oe) |-> !$past(select, 2))
		else $error("output enable fell with select high");
	a_status_no_fall: assert property (serial_out_oe && $past(serial_out_oe)
		&& $past(serial_out_oe, 2) && idle_r >= 4'h8 |-> !$fell(serial_out))
		else $error("output fell without a shift clock");
	a_busy_bounded: assert property (busy_r <= 32'(PROG_CYCLES_P + 16))
		else $error("busy status outlasts programming");
endmodule : eeprom_serial_slave_asserts

bind eeprom_serial_slave eeprom_serial_slave_asserts #(.PROG_CYCLES_P(PROG_CYCLES_P)) chk (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.shift_clock(shift_clock),
	.select(select),
	.serial_in(serial_in),
	.serial_out(serial_out),
	.serial_out_oe(serial_out_oe)
);

// >>> link_master.sv
// Bus master model that frames commands and polls status
module link_master (
	output logic      select,
	output logic      shift_clock,
	output logic      serial_in,
	input  wire logic serial_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		select = 1'b0;
		shift_clock = 1'b0;
		serial_in = 1'b0;
	end
	// Clock runs only inside frames; sel low replays a frame to be ignored
	task automatic xfer(input logic sel, input logic [31:0] bits, input int n, input int rd_n,
		output logic [16:0] rd);
		rd = 17'h00000;
		#1000;
		#1.3 select = sel;
		#200;
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = bits[i];
			#16 shift_clock = 1'b1;
			#16 shift_clock = 1'b0;
		end
		for (int j = 0; j < rd_n; j++) begin
			#14 rd = {rd[15:0], serial_out};
			#2 shift_clock = 1'b1;
			#16 shift_clock = 1'b0;
		end
		select = 1'b0;
		serial_in = ~serial_in;
	endtask : xfer
	task automatic poll(output logic first, output logic ok);
		int cyc;
		#1000;
		#1.3 select = 1'b1;
		#40 first = serial_out;
		cyc = 0;
		while (serial_out !== 1'b1 && cyc < 1500) begin
			#4 cyc++;
		end
		ok = (cyc < 1500);
		select = 1'b0;
	endtask : poll
endmodule : link_master

// >>> eeprom_serial_slave_test.sv
// Self-checking bench for the serial EEPROM slave
module eeprom_serial_slave_test
	import eeprom_pkg::*;
	;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PROG_SIM = 1000;
	logic sys_clk;
	logic rst_b;
	logic shift_clock;
	logic select;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;
	int   fail_count;
	int   cmp_count;

	initial sys_clk = 1'b0;
	always #2 sys_clk = ~sys_clk;

	eeprom_serial_slave #(.PROG_CYCLES_P(PROG_SIM)) dut (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.shift_clock(shift_clock),
		.select(select),
		.serial_in(serial_in),
		.serial_out(serial_out),
		.serial_out_oe(serial_out_oe)
	);
	link_master m (
		.select(select),
		.shift_clock(shift_clock),
		.serial_in(serial_in),
		.serial_out(serial_out)
	);

	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk_word(input logic [16:0] got, input logic [16:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: read %h not %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: status %b not %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d);
		logic [16:0] r;
		if (op == OP_WRITE || (op == OP_EXT && a[EXT_SEL_HI:EXT_SEL_LO] == FILL_ARRAY_CMD)) begin
			m.xfer(1'b1, {5'h00, 1'b1, op, a, d}, 27, 0, r);
		end else begin
			m.xfer(1'b1, {21'h000000, 1'b1, op, a}, 11, 0, r);
		end
	endtask : cmd
	// Timeout here means the device never came back ready
	task automatic wait_ready(input logic busy);
		logic first;
		logic ok;
		m.poll(first, ok);
		chk_bit(first, ~busy);
		repeat (8) @(negedge sys_clk);
		chk_bit(serial_out_oe, 1'b0);
		if (!ok) begin
			fail_count++;
			$display("mismatch at %0t: device stayed busy", $time);
			wrap_up();
		end
	endtask : wait_ready
	task automatic rd(input logic [7:0] a, input int lead, input logic [15:0] exp);
		logic [16:0] r;
		m.xfer(1'b1, {21'h000000, 1'b1, OP_READ, a}, 11 + lead, 17, r);
		chk_word(r, {1'b0, exp});
	endtask : rd
	task automatic sc_idle;
		wait_ready(1'b0);
		rd(8'h00, 0, 16'hFFFF);
	endtask : sc_idle
	task automatic sc_locked;
		cmd(OP_WRITE, 8'h05, 16'h1234);
		wait_ready(1'b0);
		rd(8'h05, 0, 16'hFFFF);
	endtask : sc_locked
	task automatic sc_write;
		cmd(OP_EXT, {PROGRAM_ENABLE_CMD, 6'h00}, 16'h0000);
		cmd(OP_WRITE, 8'h05, 16'hA5C3);
		wait_ready(1'b1);
		rd(8'h85, 3, 16'hA5C3);
	endtask : sc_write
	task automatic sc_busy;
		cmd(OP_WRITE, 8'h06, 16'h1111);
		cmd(OP_WRITE, 8'h07, 16'h2222);
		wait_ready(1'b1);
		rd(8'h06, 0, 16'h1111);
		rd(8'h07, 0, 16'hFFFF);
	endtask : sc_busy
	task automatic sc_partial;
		logic [16:0] r;
		m.xfer(1'b1, {5'h00, 1'b1, OP_WRITE, 8'h08, 16'hBEEF} >> 7, 20, 0, r);
		wait_ready(1'b0);
		m.xfer(1'b0, {5'h00, 1'b1, OP_WRITE, 8'h08, 16'hBEEF}, 27, 0, r);
		wait_ready(1'b0);
		rd(8'h08, 0, 16'hFFFF);
	endtask : sc_partial
	task automatic sc_array;
		cmd(OP_ERASE, 8'h05, 16'h0000);
		wait_ready(1'b1);
		rd(8'h05, 0, 16'hFFFF);
		cmd(OP_EXT, {FILL_ARRAY_CMD, 6'h00}, 16'h0F0F);
		wait_ready(1'b1);
		rd(8'h7F, 0, 16'h0F0F);
		rd(8'h06, 0, 16'h0F0F);
		cmd(OP_EXT, {CLEAR_ARRAY_CMD, 6'h15}, 16'h0000);
		wait_ready(1'b1);
		rd(8'h7F, 0, 16'hFFFF);
		cmd(OP_EXT, {PROGRAM_DISABLE_CMD, 6'h3F}, 16'h0000);
		cmd(OP_WRITE, 8'h09, 16'hBEEF);
		wait_ready(1'b0);
		rd(8'h09, 0, 16'hFFFF);
	endtask : sc_array

	initial begin
		rst_b = 1'b0;
		fail_count = 0;
		cmp_count = 0;
		repeat (16) @(negedge sys_clk);
		rst_b = 1'b1;
		sc_idle();
		sc_locked();
		sc_write();
		sc_busy();
		sc_partial();
		sc_array();
		wrap_up();
	end
endmodule : eeprom_serial_slave_test
